// [include/fault_cfg_pkg.sv]
/*
 * Shared constants and state types for the fault threshold block.
 * Assumes a single clock domain and command codes from the management bus engine.
 */
`default_nettype none
package fault_cfg_pkg;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] OV_THRESH_ADDR = 8'hda;
    localparam logic [7:0] UV_THRESH_ADDR = 8'hdb;
    localparam logic [7:0] OC_THRESH_ADDR = 8'hdc;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int TEMP_SEL_BIT = 9;
    localparam int RANGE_LSB = 6;
    localparam int RANGE_MSB = 8;
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 5;
    localparam int DIR_BIT = 9;
    localparam int SHUNT_RNG_BIT = 6;
    // ----------------------------------------
    // reset values and writable masks
    // ----------------------------------------
    localparam logic [15:0] OV_RESET = 16'h003f;
    localparam logic [7:0] UV_RESET = 8'h00;
    localparam logic [15:0] OC_RESET = 16'h003f;
    localparam logic [15:0] OV_MASK = 16'h03ff;
    localparam logic [7:0] UV_MASK = 8'h3f;
    localparam logic [15:0] OC_MASK = 16'h027f;
    // ----------------------------------------
    // reference arithmetic: one step is 1/64 of full scale
    // ----------------------------------------
    localparam int FRAC_SHIFT = 6;
    localparam logic [6:0] OFFSET_STEPS = 7'h10;
    localparam logic [6:0] NO_OFFSET = 7'h00;
    // bus full scale in bus-level lsb (1 mV wide part, 250 uV narrow part)
    localparam logic [15:0] FS_RANGE0 = 16'hbb80;
    localparam logic [15:0] FS_RANGE1 = 16'h5dc0;
    localparam logic [15:0] FS_RANGE2 = 16'h2ee0;
    localparam logic [15:0] FS_RANGE3 = 16'h1388;
    localparam logic [15:0] FS_RANGE4 = 16'h0ce4;
    localparam logic [15:0] FS_RANGE5 = 16'h09c4;
    // shunt full scale in 2.5 uV lsb: 80 mV and 40 mV
    localparam logic [15:0] FS_SHUNT_WIDE = 16'h7d00;
    localparam logic [15:0] FS_SHUNT_NARROW = 16'h3e80;
    // temperature in 0.01 degC: base -144.00, step 5.71
    localparam logic signed [17:0] TEMP_BASE_CDEG = -18'sh03840;
    localparam logic signed [17:0] TEMP_STEP_CDEG = 18'sh0023b;
    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef enum logic [1:0] {
        RANGE_OK = 2'b00,
        RANGE_NARROW_ONLY = 2'b01,
        RANGE_UNDEFINED = 2'b10
    } range_class_t;

    typedef struct packed {
        logic [15:0] ov;
        logic [7:0] uv;
        logic [15:0] oc;
        logic [15:0] rd_data;
        logic rd_valid;
        logic ack;
    } regs_state_t;

    typedef struct packed {
        logic [16:0] ov_ref;
        logic [16:0] uv_ref;
        logic [16:0] oc_ref;
        logic signed [17:0] temp_ref;
        logic temp_mode;
        logic range_ok;
        logic ov_trip;
        logic uv_trip;
        logic oc_trip;
    } mon_state_t;
endpackage : fault_cfg_pkg
`default_nettype wire

// [include/thresh_if.sv]
/*
 * Threshold configuration fields carried from the register store to the monitor.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface thresh_if;
    logic temp_sel;
    logic [2:0] range;
    logic [5:0] ov_code;
    logic [5:0] uv_code;
    logic [5:0] oc_code;
    logic dir;
    logic shunt_rng;
    modport store (output temp_sel, range, ov_code, uv_code, oc_code, dir, shunt_rng);
    modport use_cfg (input temp_sel, range, ov_code, uv_code, oc_code, dir, shunt_rng);
endinterface : thresh_if
`default_nettype wire

// [hw/threshold_scale.sv]
/*
 * Scales a bus or shunt full scale by a 6-bit code plus an optional offset in 1/64 steps.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ns
`default_nettype none
module threshold_scale
    import fault_cfg_pkg::*;
(
    input wire logic [15:0] full_scale,
    input wire logic [5:0] code,
    input wire logic [6:0] offset,
    output logic [16:0] level
);
    logic [22:0] product;

    always_comb begin
        product = 23'(full_scale) * 23'(7'(code) + offset);
        level = product[22:FRAC_SHIFT];
    end
endmodule : threshold_scale
`default_nettype wire

// [hw/threshold_regs.sv]
/*
 * The three threshold registers with write masks and registered read-back.
 * Assumes one command per cycle at most from the bus engine.
 */
`timescale 1ns/1ns
`default_nettype none
module threshold_regs
    import fault_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic ack,
    thresh_if.store cfg
);
    regs_state_t state;
    regs_state_t next_state;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OV_THRESH_ADDR) || (a == UV_THRESH_ADDR) || (a == OC_THRESH_ADDR);
    endfunction : is_mapped

    always_comb begin
        next_state = state;
        next_state.rd_valid = rd;
        next_state.ack = (wr || rd) && is_mapped(addr);
        if (rd) begin
            // reserved bits and unmapped codes read as zero
            case (addr)
                OV_THRESH_ADDR: next_state.rd_data = state.ov;
                UV_THRESH_ADDR: next_state.rd_data = {8'h00, state.uv};
                OC_THRESH_ADDR: next_state.rd_data = state.oc;
                default: next_state.rd_data = 16'h0000;
            endcase
        end
        if (wr && is_mapped(addr)) begin
            case (addr)
                OV_THRESH_ADDR: next_state.ov = wdata & OV_MASK;
                UV_THRESH_ADDR: next_state.uv = wdata[7:0] & UV_MASK;
                OC_THRESH_ADDR: next_state.oc = wdata & OC_MASK;
                default: next_state.ov = state.ov;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= '{ov: OV_RESET, uv: UV_RESET, oc: OC_RESET, rd_data: 16'h0000,
                       rd_valid: 1'b0, ack: 1'b0};
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign rdata = state.rd_data;
    assign rvalid = state.rd_valid;
    assign ack = state.ack;
    assign cfg.temp_sel = state.ov[TEMP_SEL_BIT];
    assign cfg.range = state.ov[RANGE_MSB:RANGE_LSB];
    assign cfg.ov_code = state.ov[CODE_MSB:CODE_LSB];
    assign cfg.uv_code = state.uv[CODE_MSB:CODE_LSB];
    assign cfg.oc_code = state.oc[CODE_MSB:CODE_LSB];
    assign cfg.dir = state.oc[DIR_BIT];
    assign cfg.shunt_rng = state.oc[SHUNT_RNG_BIT];
endmodule : threshold_regs
`default_nettype wire

// [hw/fault_threshold_config.sv]
/*
 * Fault threshold configuration and digital comparators of the power monitor.
 * Holds the three threshold registers, derives the overvoltage, undervoltage,
 * overcurrent and temperature references, and compares the measured levels.
 * Assumes the measured levels come from logic on SYS_CLK, so they are not
 * synchronised, and that the bus engine issues at most one command per cycle.
 */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - three comparators, overvoltage switchable to temperature
// - ov word: select, range, code fields
// - select bit routes temperature, else bus
// - one range shared by ov and uv
// - range codes map to full scales
// - ov reference is 25% plus code steps
// - temperature reference -144 C, 5.71 C/step
// - uv byte: code only, reference code steps
// - uv full scale from ov range field
// - oc word: direction, shunt range, code
// - direction bit picks current polarity
// - shunt range 80 mV or 40 mV
// - oc reference is 25% plus code steps
module fault_threshold_config
    import fault_cfg_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1
)
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    output logic [15:0] CMD_RDATA,
    output logic CMD_RVALID,
    output logic CMD_ACK,
    input wire logic [15:0] BUS_LEVEL,
    input wire logic signed [15:0] SHUNT_LEVEL,
    input wire logic signed [15:0] TEMP_LEVEL,
    output logic [16:0] OV_REF,
    output logic [16:0] UV_REF,
    output logic [16:0] OC_REF,
    output logic signed [17:0] TEMP_REF,
    output logic TEMP_MODE,
    output logic RANGE_VALID,
    output logic OV_OT_TRIP,
    output logic UV_TRIP,
    output logic OC_TRIP
);
    // ----------------------------------------
    // register store
    // ----------------------------------------
    thresh_if cfg ();

    threshold_regs u_regs (
        .clk(SYS_CLK),
        .nrst(NRST),
        .ce(CE),
        .addr(CMD_CODE),
        .wdata(CMD_WDATA),
        .wr(CMD_WR),
        .rd(CMD_RD),
        .rdata(CMD_RDATA),
        .rvalid(CMD_RVALID),
        .ack(CMD_ACK),
        .cfg(cfg.store)
    );

    // ----------------------------------------
    // range decoding
    // ----------------------------------------
    function automatic range_class_t classify(input logic [2:0] code, input logic wide);
        range_class_t cls;
        case (code)
            3'h0, 3'h1, 3'h2, 3'h3: cls = RANGE_OK;
            3'h4, 3'h5: cls = wide ? RANGE_OK : RANGE_NARROW_ONLY;
            default: cls = RANGE_UNDEFINED;
        endcase
        return cls;
    endfunction : classify

    function automatic logic [15:0] bus_full_scale(input logic [2:0] code);
        logic [15:0] fs;
        case (code)
            3'h0: fs = FS_RANGE0;
            3'h1: fs = FS_RANGE1;
            3'h2: fs = FS_RANGE2;
            3'h3: fs = FS_RANGE3;
            3'h4: fs = FS_RANGE4;
            3'h5: fs = FS_RANGE5;
            default: fs = FS_RANGE0;
        endcase
        return fs;
    endfunction : bus_full_scale

    range_class_t range_class;
    logic [15:0] bus_fs;
    logic [15:0] shunt_fs;

    always_comb begin
        range_class = classify(cfg.range, WIDE_VARIANT);
        bus_fs = bus_full_scale(cfg.range);
        shunt_fs = cfg.shunt_rng ? FS_SHUNT_NARROW : FS_SHUNT_WIDE;
    end

    // ----------------------------------------
    // reference scaling
    // ----------------------------------------
    logic [16:0] ov_level;
    logic [16:0] uv_level;
    logic [16:0] oc_level;

    threshold_scale u_ov_scale (
        .full_scale(bus_fs),
        .code(cfg.ov_code),
        .offset(OFFSET_STEPS),
        .level(ov_level)
    );

    threshold_scale u_uv_scale (
        .full_scale(bus_fs),
        .code(cfg.uv_code),
        .offset(NO_OFFSET),
        .level(uv_level)
    );

    threshold_scale u_oc_scale (
        .full_scale(shunt_fs),
        .code(cfg.oc_code),
        .offset(OFFSET_STEPS),
        .level(oc_level)
    );

    logic signed [17:0] temp_level;

    always_comb begin
        temp_level = TEMP_BASE_CDEG + TEMP_STEP_CDEG * $signed({12'h000, cfg.ov_code});
    end

    // ----------------------------------------
    // comparators
    // ----------------------------------------
    mon_state_t state;
    mon_state_t next_state;
    logic signed [17:0] bus_ext;
    logic signed [17:0] temp_ext;
    logic signed [17:0] shunt_dir;
    logic signed [17:0] oc_ref_ext;
    logic signed [17:0] high_sel_level;
    logic signed [17:0] high_sel_ref;

    always_comb begin
        bus_ext = $signed({2'b00, BUS_LEVEL});
        temp_ext = 18'(TEMP_LEVEL);
        oc_ref_ext = $signed({1'b0, state.oc_ref});
        shunt_dir = cfg.dir ? -18'(SHUNT_LEVEL) : 18'(SHUNT_LEVEL);
        if (state.temp_mode) begin
            high_sel_level = temp_ext;
            high_sel_ref = state.temp_ref;
        end else begin
            high_sel_level = bus_ext;
            high_sel_ref = $signed({1'b0, state.ov_ref});
        end
    end

    always_comb begin
        next_state = state;
        next_state.ov_ref = ov_level;
        next_state.uv_ref = uv_level;
        next_state.oc_ref = oc_level;
        next_state.temp_ref = temp_level;
        next_state.temp_mode = cfg.temp_sel;
        // undefined or absent ranges hold the bus comparators quiet
        next_state.range_ok = (range_class == RANGE_OK);
        next_state.ov_trip = (state.temp_mode || state.range_ok) && (high_sel_level > high_sel_ref);
        next_state.uv_trip = state.range_ok && (bus_ext < $signed({1'b0, state.uv_ref}));
        next_state.oc_trip = shunt_dir > oc_ref_ext;
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state <= '{ov_ref: 17'h00000, uv_ref: 17'h00000, oc_ref: 17'h00000,
                       temp_ref: 18'sh00000, temp_mode: 1'b0, range_ok: 1'b0,
                       ov_trip: 1'b0, uv_trip: 1'b0, oc_trip: 1'b0};
        end else if (CE) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign OV_REF = state.ov_ref;
    assign UV_REF = state.uv_ref;
    assign OC_REF = state.oc_ref;
    assign TEMP_REF = state.temp_ref;
    assign TEMP_MODE = state.temp_mode;
    assign RANGE_VALID = state.range_ok;
    assign OV_OT_TRIP = state.ov_trip;
    assign UV_TRIP = state.uv_trip;
    assign OC_TRIP = state.oc_trip;
endmodule : fault_threshold_config
`default_nettype wire

// [testbench/fault_threshold_sva.sv]
/* Assertions on the fault threshold block ports.
   Assumes CE stays high across each checked write. */
`timescale 1ns/1ns
`default_nettype none
module fault_threshold_sva
    import fault_cfg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [15:0] CMD_RDATA,
    input wire logic CMD_RVALID,
    input wire logic CMD_ACK,
    input wire logic [15:0] BUS_LEVEL,
    input wire logic signed [15:0] TEMP_LEVEL,
    input wire logic [16:0] UV_REF,
    input wire logic [16:0] OV_REF,
    input wire logic [16:0] OC_REF,
    input wire logic signed [17:0] TEMP_REF,
    input wire logic TEMP_MODE,
    input wire logic RANGE_VALID,
    input wire logic OV_OT_TRIP,
    input wire logic UV_TRIP,
    input wire logic OC_TRIP
);
    wire logic mapped = CMD_CODE inside {OV_THRESH_ADDR, UV_THRESH_ADDR, OC_THRESH_ADDR};
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // second cycle with CE high lets the reference land
    sequence ov_wr;
        CE && CMD_WR && CMD_CODE == OV_THRESH_ADDR ##1 CE;
    endsequence
    sequence oc_wr;
        CE && CMD_WR && CMD_CODE == OC_THRESH_ADDR ##1 CE;
    endsequence
    AST_ACK: assert property (CE |=> CMD_ACK == $past((CMD_WR || CMD_RD) && mapped))
        else $error("ack not tied to mapped request");
    AST_RVALID: assert property (CE |=> CMD_RVALID == $past(CMD_RD))
        else $error("read answer missing");
    AST_UV_RD: assert property (CE && CMD_RD && CMD_CODE == UV_THRESH_ADDR |=> CMD_RDATA[15:6] == 10'h000)
        else $error("low threshold read shows reserved bits");
    AST_TMODE: assert property (ov_wr |=> TEMP_MODE == $past(CMD_WDATA[9], 2))
        else $error("temperature select not applied");
    AST_TEMP_REF: assert property (ov_wr |=> TEMP_REF == 18'(-14400 + 571 * $past(CMD_WDATA[5:0], 2)))
        else $error("temperature reference wrong");
    AST_OC_REF: assert property (oc_wr |=>
        OC_REF == 17'((($past(CMD_WDATA[6], 2)) ? 16000 : 32000) * (16 + $past(CMD_WDATA[5:0], 2)) >> 6))
        else $error("overcurrent reference wrong");
    AST_OV_TRIP: assert property (CE && !TEMP_MODE |=> OV_OT_TRIP == $past(RANGE_VALID && BUS_LEVEL > OV_REF))
        else $error("overvoltage trip wrong");
    AST_OT_TRIP: assert property (CE && TEMP_MODE |=> OV_OT_TRIP == $past(TEMP_LEVEL > TEMP_REF))
        else $error("over-temperature trip wrong");
    AST_UV_TRIP: assert property (CE |=> UV_TRIP == $past(RANGE_VALID && BUS_LEVEL < UV_REF))
        else $error("undervoltage trip wrong");
    COV_OT: cover property (TEMP_MODE && OV_OT_TRIP);
    COV_OC: cover property ($rose(OC_TRIP));
    COV_UV: cover property (UV_TRIP);
endmodule : fault_threshold_sva
bind fault_threshold_config fault_threshold_sva fault_threshold_sva_inst (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_WR(CMD_WR),
    .CMD_RD(CMD_RD), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID), .CMD_ACK(CMD_ACK), .BUS_LEVEL(BUS_LEVEL),
    .TEMP_LEVEL(TEMP_LEVEL), .UV_REF(UV_REF), .OV_REF(OV_REF), .OC_REF(OC_REF), .TEMP_REF(TEMP_REF),
    .TEMP_MODE(TEMP_MODE), .RANGE_VALID(RANGE_VALID), .OV_OT_TRIP(OV_OT_TRIP), .UV_TRIP(UV_TRIP),
    .OC_TRIP(OC_TRIP));
`default_nettype wire

// [testbench/host_model.sv]
/* Management bus host issuing one command per cycle.
   Assumes calls are serialised; released lines toggle so nothing reads stale data. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic clk,
    output logic [7:0] code,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        code = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic cmd(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #2;
        code = a;
        wdata = d;
        wr = w;
        rd = r;
    endtask : cmd
    task automatic idle();
        @(posedge clk);
        #2;
        wr = 1'b0;
        rd = 1'b0;
        code = ~code;
        wdata = ~wdata;
    endtask : idle
endmodule : host_model
`default_nettype wire

// [testbench/fault_threshold_config_tb.sv]
/* Self-checking bench for the fault threshold block.
   Assumes host_model drives the command port; CE is driven by the bench. */
`timescale 1ns/1ns
`default_nettype none
module fault_threshold_config_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    wire logic wr, rd;
    wire logic [7:0] code;
    wire logic [15:0] wdata;
    logic [15:0] rdata, bus_lvl = 16'h0000;
    logic signed [15:0] shunt_lvl = 16'sh0000, temp_lvl = 16'sh0000;
    logic rvalid, ack, temp_mode, rng_ok, ov_trip, uv_trip, oc_trip;
    logic [16:0] ov_ref, uv_ref, oc_ref;
    logic signed [17:0] temp_ref;
    logic [15:0] exp_q[$];
    int error_cnt = 0, n_checks = 0, r, c, x;
    int fs[6] = '{48000, 24000, 12000, 5000, 3300, 2500};
    always #25 sys_clk = ~sys_clk;
    host_model host_model_inst (.clk(sys_clk), .code(code), .wdata(wdata), .wr(wr), .rd(rd));
    fault_threshold_config fault_threshold_config_inst (
        .SYS_CLK(sys_clk), .NRST(nrst), .CE(ce), .CMD_CODE(code), .CMD_WDATA(wdata), .CMD_WR(wr),
        .CMD_RD(rd), .CMD_RDATA(rdata), .CMD_RVALID(rvalid), .CMD_ACK(ack), .BUS_LEVEL(bus_lvl),
        .SHUNT_LEVEL(shunt_lvl), .TEMP_LEVEL(temp_lvl), .OV_REF(ov_ref), .UV_REF(uv_ref), .OC_REF(oc_ref),
        .TEMP_REF(temp_ref), .TEMP_MODE(temp_mode), .RANGE_VALID(rng_ok), .OV_OT_TRIP(ov_trip),
        .UV_TRIP(uv_trip), .OC_TRIP(oc_trip));
    task automatic chk(input string what, input logic [17:0] expv, input logic [17:0] got);
        n_checks++;
        if (got !== expv) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, expv, got);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // a read notes its expected word before the request goes out
    task automatic op(input logic w, input logic rdn, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        if (rdn) begin
            exp_q.push_back(e);
        end
        host_model_inst.cmd(w, rdn, a, d);
    endtask : op
    task automatic settle(input int n);
        int k;
        host_model_inst.idle();
        for (k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge sys_clk);
        if (exp_q.size() > 0) begin
            error_cnt++;
            $display("ERROR read answers expected %0d seen 0", exp_q.size());
            conclude();
        end
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : settle
    always @(negedge sys_clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("read count", 18'h00000, 18'h00001);
            end else begin
                chk("rdata", 18'(exp_q.pop_front()), 18'(rdata));
            end
        end
    end
    initial begin
        x = $urandom(12871);
        repeat (12) @(posedge sys_clk);
        #2;
        nrst = 1'b1;
        settle(2);
        chk("ov_ref", 18'h0e772, 18'(ov_ref));
        chk("oc_ref", 18'h09a4c, 18'(oc_ref));
        chk("range_valid", 18'h00001, 18'(rng_ok));
        op(1'b0, 1'b1, 8'hda, 16'h0000, 16'h003f);
        op(1'b0, 1'b1, 8'hdb, 16'h0000, 16'h0000);
        op(1'b1, 1'b1, 8'hdc, 16'hffff, 16'h003f);
        op(1'b1, 1'b0, 8'hda, 16'hfffe, 16'h0000);
        op(1'b1, 1'b0, 8'hdb, 16'hffff, 16'h0000);
        op(1'b1, 1'b1, 8'hdd, 16'hffff, 16'h0000);
        op(1'b0, 1'b1, 8'hda, 16'h0000, 16'h03fe);
        op(1'b0, 1'b1, 8'hdb, 16'h0000, 16'h003f);
        op(1'b0, 1'b1, 8'hdc, 16'h0000, 16'h027f);
        settle(1);
        // with the enable low neither the write lands nor a read answers
        ce = 1'b0;
        host_model_inst.cmd(1'b1, 1'b1, 8'hdb, 16'h0015);
        settle(2);
        ce = 1'b1;
        op(1'b0, 1'b1, 8'hdb, 16'h0000, 16'h003f);
        settle(1);
        // every range code, the undefined ones must silence the bus trips
        for (r = 0; r < 8; r++) begin
            c = $urandom_range(62);
            x = $urandom_range(63);
            bus_lvl = 16'h0000;
            op(1'b1, 1'b0, 8'hda, 16'(r * 64 + c), 16'h0000);
            op(1'b1, 1'b0, 8'hdb, 16'(x), 16'h0000);
            settle(3);
            chk("range_valid", 18'(r < 6), 18'(rng_ok));
            if (r < 6) begin
                chk("ov_ref", 18'(fs[r] * (16 + c) >> 6), 18'(ov_ref));
                chk("uv_ref", 18'(fs[r] * x >> 6), 18'(uv_ref));
                chk("uv_trip", 18'(fs[r] * x >= 64), 18'(uv_trip));
                bus_lvl = 16'((fs[r] * (16 + c) >> 6) + 1);
                settle(2);
                chk("ov_trip", 18'h00001, 18'(ov_trip));
            end else begin
                chk("uv_trip", 18'h00000, 18'(uv_trip));
                // a full-scale bus level would trip the high comparator if not held quiet
                bus_lvl = 16'hffff;
                settle(2);
                chk("ov_trip", 18'h00000, 18'(ov_trip));
            end
        end
        c = $urandom_range(62);
        bus_lvl = 16'hffff;
        temp_lvl = 16'(-14400 + 571 * c + 1);
        op(1'b1, 1'b0, 8'hda, 16'h0200 | 16'(c), 16'h0000);
        settle(3);
        chk("temp_mode", 18'h00001, 18'(temp_mode));
        chk("temp_ref", 18'(-14400 + 571 * c), temp_ref);
        chk("ot_trip", 18'h00001, 18'(ov_trip));
        temp_lvl = temp_lvl - 16'sh0001;
        settle(2);
        chk("ot_trip", 18'h00000, 18'(ov_trip));
        // both directions and both shunt ranges
        for (r = 0; r < 4; r++) begin
            c = $urandom_range(49);
            x = ((r & 1) ? 16000 : 32000) * (16 + c) >> 6;
            shunt_lvl = 16'((r >> 1) ? -(x + 1) : x + 1);
            op(1'b1, 1'b0, 8'hdc, 16'((r >> 1) * 512 + (r & 1) * 64 + c), 16'h0000);
            settle(3);
            chk("oc_ref", 18'(x), 18'(oc_ref));
            chk("oc_trip", 18'h00001, 18'(oc_trip));
            shunt_lvl = -shunt_lvl;
            settle(2);
            chk("oc_trip", 18'h00000, 18'(oc_trip));
        end
        // mid-run reset must bring back the register defaults
        nrst = 1'b0;
        settle(2);
        chk("temp_mode", 18'h00000, 18'(temp_mode));
        chk("ov_ref", 18'h00000, 18'(ov_ref));
        nrst = 1'b1;
        settle(2);
        chk("ov_ref", 18'h0e772, 18'(ov_ref));
        op(1'b0, 1'b1, 8'hdc, 16'h0000, 16'h003f);
        settle(1);
        conclude();
    end
endmodule : fault_threshold_config_tb
`default_nettype wire
